// file: contactor_model.sv
// Purpose: Contactor with a linked auxiliary contact
// Assumes: Coil driven straight from the switching output
// Notes: A stuck contact and a slow contact (set by lag) are the misbehaviours offered
`timescale 1ns/1ns
module contactor_model (
    // Clock and coil
    input wire logic mclk,
    input wire logic coil,
    // Behaviour set by the bench
    input wire logic [31:0] lag,
    input wire logic stuck,
    // Auxiliary contact
    output logic feedback = 1'b1
);
    logic last_ff = 1'b0; // Coil level last seen
    int cnt_ff = 0; // Cycles since the coil moved
    // Contact shows the inverse of the coil after lag cycles; no extra delay after the outputs
    // A released coil keeps the contact closed, which the clear sequence needs
    always @(posedge mclk) begin
        if (coil !== last_ff) begin
            last_ff <= coil;
            cnt_ff <= 0;
        end else if (cnt_ff < lag) begin
            cnt_ff <= cnt_ff + 1;
        end else if (!stuck) begin
            feedback <= !coil;
        end
    end
endmodule // contactor_model

// file: feedback_monitor.sv
// Purpose: Drives two redundant switching outputs and checks contactor feedback
// Assumes: Inputs from pins, synchronised here; delay given in 10 ms steps
// Notes: run_start pulses on an idle-to-execution change and resets the logic
`timescale 1ns/1ns
`include "feedback_monitor_defs.svh"

// Function
// R1 - Outputs follow safe input when no fault
// R2 - Feedback must change within configured delay
// R3 - Expected feedback is inverse of outputs
// R4 - Timeout sets error, fault, outputs off
// R5 - Delay in 10 ms steps, default 300
// R6 - Fault flag shows feedback mismatch
// R7 - Error clears on input rising, no other error
// R8 - Contactor holds feedback active during clear
// R9 - Re-enabled outputs need feedback off in time
// R10 - Idle-to-execution restart resets the monitor
// R11 - Delays belong upstream, not downstream
// R12 - Timer restarts per change, counts steps
module feedback_monitor #(
    parameter int STEP_CYCLES = `FBM_STEP_CYCLES,
    parameter logic [`FBM_STEP_W-1:0] DELAY_DEF = `FBM_STEP_W'(`FBM_DELAY_DEF_STEPS)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Controller status and configuration
    input wire logic run_start,
    input wire logic [`FBM_STEP_W-1:0] delay_steps,
    input wire logic other_error,
    // Safety-capable input and contactor feedback
    input wire logic safe_in,
    input wire logic contactor_feedback,
    // Switching outputs and diagnostics
    output logic switch_out_a,
    output logic switch_out_b,
    output logic feedback_error,
    output logic fault_present
);
    import feedback_monitor_pkg::*;

    localparam logic [`FBM_STEP_W-1:0] DMIN = `FBM_STEP_W'(`FBM_DELAY_MIN_STEPS);
    localparam logic [`FBM_STEP_W-1:0] DMAX = `FBM_STEP_W'(`FBM_DELAY_MAX_STEPS);

    // Elaboration check on parameters
    if (DELAY_DEF < DMIN || DELAY_DEF > DMAX) begin : g_bad_def
        $error("feedback_monitor: DELAY_DEF out of range");
    end
    if (STEP_CYCLES < 2) begin : g_bad_step
        $error("feedback_monitor: STEP_CYCLES too small");
    end

    // Clamp a requested delay into the legal window
    function automatic logic [`FBM_STEP_W-1:0] clamp_delay(input logic [`FBM_STEP_W-1:0] d);
        if (d < DMIN) return DMIN;
        if (d > DMAX) return DMAX;
        return d;
    endfunction

    logic rst_meta_ff; // Reset release stage 1
    logic rst_sync_ff; // Reset release stage 2
    logic [2:0] in_meta_ff; // Pin stage 1: safe_in, feedback, run_start
    logic [2:0] in_sync_ff; // Pin stage 2
    logic safe_prev_ff; // Last safe input, for edge detection
    logic run_prev_ff; // Last run_start level
    logic out_ff; // Common level of both switching outputs
    logic err_ff; // Feedback error
    logic checking_ff; // Feedback check pending
    logic [`FBM_STEP_W-1:0] delay_ff; // Delay captured at restart
    logic [`FBM_STEP_W-1:0] steps_ff; // Steps elapsed since output change
    mon_state_t state_ff; // Monitor state
    logic nxt_out; // Next output level
    logic safe_s; // Synchronised safe input
    logic fb_s; // Synchronised feedback
    logic restart; // Logic reset event
    logic out_change; // Output is about to change
    logic fb_ok; // Feedback at its expected level
    logic timeout; // Feedback delay expired
    step_tick_if step_if ();

    // Release reset through two flops; assert stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Two-flop synchronisers for the pin inputs
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            in_meta_ff <= 3'h0;
            in_sync_ff <= 3'h0;
        end else begin
            in_meta_ff <= {run_start, contactor_feedback, safe_in};
            in_sync_ff <= in_meta_ff;
        end
    end

    assign safe_s = in_sync_ff[0];
    assign fb_s = in_sync_ff[1];
    // Rising edge of the controller run request resets the monitor
    assign restart = in_sync_ff[2] && !run_prev_ff; // [R10]

    // Edge history
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            safe_prev_ff <= 1'b0;
            run_prev_ff <= 1'b0;
        end else begin
            safe_prev_ff <= safe_s;
            run_prev_ff <= in_sync_ff[2];
        end
    end

    // Output level: follows input only in the run state
    always_comb begin
        nxt_out = 1'b0;
        if (!restart && state_ff == ST_RUN && !timeout) begin
            nxt_out = safe_s; // [R1]
        end
    end

    assign out_change = (nxt_out != out_ff);
    // Feedback must be the inverse of the outputs
    assign fb_ok = (fb_s == !out_ff); // [R3]
    assign timeout = checking_ff && !fb_ok && (steps_ff >= delay_ff); // [R2] [R12]

    // Step divider, realigned at every output change
    step_divider #(
        .CYCLES(STEP_CYCLES)
    ) u_div (
        .mclk(mclk),
        .rst_n(rst_sync_ff),
        .restart(out_change || restart),
        .step(step_if.src)
    );

    // Capture delay setting; default until the controller restarts
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            delay_ff <= DELAY_DEF; // [R5]
        end else if (restart) begin
            delay_ff <= clamp_delay(delay_steps); // [R5]
        end
    end

    // Feedback timer: restart on each change, stop once matched
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            checking_ff <= 1'b0;
            steps_ff <= '0;
        end else if (restart || timeout) begin
            checking_ff <= 1'b0;
            steps_ff <= '0;
        end else if (out_change) begin
            checking_ff <= 1'b1; // [R12] [R9]
            steps_ff <= '0;
        end else if (checking_ff && fb_ok) begin
            checking_ff <= 1'b0;
        end else if (checking_ff && step_if.tick && steps_ff != DMAX) begin
            steps_ff <= steps_ff + 1'b1;
        end
    end

    // Monitor state and error flag
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= ST_RUN;
            err_ff <= 1'b0;
        end else if (restart) begin
            state_ff <= ST_RUN; // [R10]
            err_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (timeout) begin
                        state_ff <= ST_FAULT; // [R4]
                        err_ff <= 1'b1;
                    end
                end
                ST_FAULT: begin
                    // Clear needs a fresh off-to-on edge, feedback held active
                    if (safe_s && !safe_prev_ff && !other_error && fb_s) begin
                        state_ff <= ST_RUN; // [R7] [R8]
                        err_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // Registered outputs; both channels carry the same level
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            out_ff <= 1'b0;
            switch_out_a <= 1'b0;
            switch_out_b <= 1'b0;
            feedback_error <= 1'b0;
            fault_present <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            switch_out_a <= nxt_out; // [R1] [R4]
            switch_out_b <= nxt_out;
            feedback_error <= (err_ff || timeout) && !restart; // [R4]
            fault_present <= (err_ff || timeout) && !restart; // [R6]
        end
    end
    // Downstream delays are invisible here and would break timing [R11]
endmodule // feedback_monitor

// file: feedback_monitor_defs.svh
// Purpose: Constants for the contactor feedback monitor
// Assumes: Controller scan clock at 100 MHz, one scan tick per 10 ms step
// Notes: Times in ms, cycle counts derived from the clock rate
`ifndef FEEDBACK_MONITOR_DEFS_SVH
`define FEEDBACK_MONITOR_DEFS_SVH
`define FBM_CLK_HZ 100000000
`define FBM_STEP_MS 10
`define FBM_STEP_CYCLES ((`FBM_CLK_HZ / 1000) * `FBM_STEP_MS)
`define FBM_DELAY_MIN_MS 100
`define FBM_DELAY_MAX_MS 1000
`define FBM_DELAY_DEF_MS 300
`define FBM_DELAY_MIN_STEPS (`FBM_DELAY_MIN_MS / `FBM_STEP_MS)
`define FBM_DELAY_MAX_STEPS (`FBM_DELAY_MAX_MS / `FBM_STEP_MS)
`define FBM_DELAY_DEF_STEPS (`FBM_DELAY_DEF_MS / `FBM_STEP_MS)
`define FBM_STEP_W 7
`endif

// file: feedback_monitor_monitor.sv
// Purpose: Port checker for the contactor feedback monitor
// Assumes: Bound to every feedback_monitor instance
// Notes: Timeout bounds allow a few cycles for the input syncs
`timescale 1ns/1ns
`include "feedback_monitor_defs.svh"
module fbm_checker #(
    parameter int STEP_CYCLES = 10,
    parameter logic [`FBM_STEP_W-1:0] DELAY_DEF = 7'h1E
) (
    // Clock, reset and inputs
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run_start,
    input wire logic [`FBM_STEP_W-1:0] delay_steps,
    input wire logic other_error,
    input wire logic safe_in,
    input wire logic contactor_feedback,
    // Outputs under watch
    input wire logic switch_out_a,
    input wire logic switch_out_b,
    input wire logic feedback_error,
    input wire logic fault_present
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    int age_ff; // Cycles since the outputs last moved
    int lim_ff; // Expected timeout in cycles
    int clr_ff; // Cycles since the last clear cause
    // Age and limit; the limit is clamped like the design clamps it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            age_ff <= 0;
            lim_ff <= int'(DELAY_DEF) * STEP_CYCLES;
        end else begin
            age_ff <= ($changed(switch_out_a) || $rose(run_start)) ? 0 : age_ff + 1;
            if ($rose(run_start))
                lim_ff <= (delay_steps < 7'h0A ? 10 : delay_steps > 7'h64 ? 100 : int'(delay_steps)) * STEP_CYCLES;
        end
    end
    // Saturating so a stale clear cause never wraps back into range
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            clr_ff <= 1000;
        else if (($rose(safe_in) && !other_error) || $rose(run_start))
            clr_ff <= 0;
        else if (clr_ff < 1000)
            clr_ff <= clr_ff + 1;
    end
    a_twin_outputs: assert property (switch_out_a == switch_out_b)
        else $error("switch outputs differ");
    a_follow_rise: assert property ($rose(switch_out_a) |-> $past(safe_in, 3) && !feedback_error)
        else $error("outputs rose without input");
    a_follow_fall: assert property ($fell(switch_out_a) && !feedback_error |-> !$past(safe_in, 3))
        else $error("outputs fell without cause");
    a_fault_mirror: assert property (fault_present == feedback_error)
        else $error("fault flag disagrees with error");
    a_error_forces_off: assert property (feedback_error |-> !switch_out_a && !switch_out_b)
        else $error("outputs on during error");
    a_timeout_exact: assert property ($rose(feedback_error) |-> age_ff >= lim_ff - 3 && age_ff <= lim_ff + 4)
        else $error("error raised at wrong time");
    a_error_mismatch: assert property ($rose(feedback_error) |-> $past(contactor_feedback, 4) == $past(switch_out_a))
        else $error("error raised with good feedback");
    a_clear_cause: assert property ($fell(feedback_error) |-> clr_ff <= 8)
        else $error("error cleared without cause");
    a_restart_clears: assert property ($rose(run_start) |-> ##[1:6] !feedback_error)
        else $error("restart left error set");
    c_timeout: cover property ($rose(feedback_error));
    c_cleared: cover property ($fell(feedback_error));
    c_enabled: cover property ($rose(switch_out_a));
endmodule // fbm_checker

bind feedback_monitor fbm_checker #(.STEP_CYCLES(STEP_CYCLES), .DELAY_DEF(DELAY_DEF)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .run_start(run_start), .delay_steps(delay_steps),
    .other_error(other_error), .safe_in(safe_in), .contactor_feedback(contactor_feedback),
    .switch_out_a(switch_out_a), .switch_out_b(switch_out_b),
    .feedback_error(feedback_error), .fault_present(fault_present));

// file: feedback_monitor_pkg.sv
// Purpose: Types shared by the contactor feedback monitor
// Assumes: Nothing beyond the constants header
// Notes: Holds the monitor state enumeration only
package feedback_monitor_pkg;
    // Monitor state
    typedef enum logic [1:0] {
        ST_RUN,
        ST_FAULT,
        ST_WAIT_OFF
    } mon_state_t;
endpackage

// file: step_divider.sv
// Purpose: Divides mclk down to one pulse per delay step
// Assumes: Reset copy from the top, asserted asynchronously, released in sync with mclk
// Notes: Restart realigns the step grid with an output change
`timescale 1ns/1ns
`include "feedback_monitor_defs.svh"
module step_divider #(
    parameter int CYCLES = `FBM_STEP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    // Tick out
    step_tick_if.src step
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_ff; // Cycles within current step
    // Elaboration check: a step of one cycle could never produce a gap between ticks
    if (CYCLES < 2) begin : g_bad_cycles
        $error("step_divider: CYCLES too small");
    end
    // Count and wrap; restart keeps timing exact from the change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (restart || cnt_ff == CW'(CYCLES - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
    assign step.tick = !restart && (cnt_ff == CW'(CYCLES - 1));
endmodule // step_divider

// file: step_tick_if.sv
// Purpose: Carries the step tick from the divider to the monitor
// Assumes: Single clock domain
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ns
interface step_tick_if;
    logic tick; // One pulse per step
    modport src (output tick);
    modport dst (input tick);
endinterface // step_tick_if

// file: testbench.sv
// Purpose: Self-checking bench for the contactor feedback monitor
// Assumes: Step of 10 cycles to keep runs short
// Notes: Partner contactor answers with a set lag or sticks
`timescale 1ns/1ns
module testbench;
    logic mclk, rst_n, run_start, other_error, safe_in, stuck, fb, sa, sb, ferr, fp;
    logic [6:0] delay_steps;
    int lag, err_count, cmp_count, cyc;
    feedback_monitor #(.STEP_CYCLES(10)) dut_u (.mclk(mclk), .rst_n(rst_n), .run_start(run_start),
        .delay_steps(delay_steps), .other_error(other_error), .safe_in(safe_in),
        .contactor_feedback(fb), .switch_out_a(sa), .switch_out_b(sb),
        .feedback_error(ferr), .fault_present(fp));
    contactor_model partner_u (.mclk(mclk), .coil(sa), .lag(lag), .stuck(stuck), .feedback(fb));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("counts: %0d compared, %0d bad", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Stuck contact at the default 30-step delay
    task automatic t_default();
        @(posedge mclk);
        stuck <= 1'b1;
        safe_in <= 1'b1;
        tick(3);
        chk("out_a", 1'b1, sa);
        chk("out_b", 1'b1, sb);
        tick(295);
        chk("early_err", 1'b0, ferr);
        tick(15);
        chk("err", 1'b1, ferr);
        chk("fault", 1'b1, fp);
        chk("out_off", 1'b0, sa);
        $display("test default done");
    endtask
    // Clear blocked by another error, then allowed; both edges then pass
    task automatic t_clear();
        @(posedge mclk);
        stuck <= 1'b0;
        other_error <= 1'b1;
        safe_in <= 1'b0;
        tick(5);
        @(posedge mclk) safe_in <= 1'b1;
        tick(8);
        chk("blocked", 1'b1, ferr);
        @(posedge mclk);
        other_error <= 1'b0;
        safe_in <= 1'b0;
        tick(5);
        @(posedge mclk) safe_in <= 1'b1;
        tick(6);
        chk("cleared", 1'b0, ferr);
        chk("out_back", 1'b1, sa);
        tick(400);
        chk("on_ok", 1'b0, ferr);
        @(posedge mclk) safe_in <= 1'b0;
        tick(4);
        chk("off", 1'b0, sa);
        tick(400);
        chk("off_ok", 1'b0, ferr);
        $display("test clear done");
    endtask
    // Shorter delay loaded at restart, slow contact, restart clears; a too-small delay is clamped
    task automatic t_restart();
        @(posedge mclk);
        delay_steps <= 7'h0A;
        lag <= 150;
        run_start <= 1'b1;
        tick(10);
        @(posedge mclk) safe_in <= 1'b1;
        tick(98);
        chk("early_err", 1'b0, ferr);
        tick(15);
        chk("slow_err", 1'b1, ferr);
        @(posedge mclk) run_start <= 1'b0;
        tick(3);
        @(posedge mclk);
        delay_steps <= 7'h02;
        run_start <= 1'b1;
        tick(8);
        chk("restart", 1'b0, ferr);
        chk("restart_f", 1'b0, fp);
        tick(50);
        chk("clamp_early", 1'b0, ferr);
        tick(55);
        chk("clamp_err", 1'b1, ferr);
        $display("test restart done");
    endtask
    // Cut a hang short
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        run_start = 1'b0;
        delay_steps = 7'h1E;
        other_error = 1'b0;
        safe_in = 1'b0;
        stuck = 1'b0;
        lag = 5;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        tick(6);
        t_default();
        t_clear();
        t_restart();
        give_verdict();
    end
endmodule // testbench
